// >>> src/admit_consts.svh
// Constants of the command admission block: opcodes, status codes,
// register offsets, field positions and the default queue depth.
// Assumes it is included once per compile unit by its bare name.
`ifndef ADMIT_CONSTS_SVH
`define ADMIT_CONSTS_SVH

// ----------------------------------------------------------------
// Opcodes and task management codes
// ----------------------------------------------------------------
`define OP_REQ_SENSE   8'h03
`define OP_INQUIRY     8'h12
`define OP_RESERVE     8'h16
`define OP_RELEASE     8'h17
`define OP_REPORT_LUNS 8'hA0
`define TMF_ABORT      2'h0
`define TMF_ABORT_SET  2'h1
`define TMF_CLEAR_SET  2'h2
`define TMF_TGT_RESET  2'h3

// ----------------------------------------------------------------
// Status bytes, sense codes, termination scopes
// ----------------------------------------------------------------
`define ST_GOOD        8'h00
`define ST_CHECK       8'h02
`define ST_CONFLICT    8'h18
`define ST_QFULL       8'h28
`define ERR_CURRENT    8'h70
`define ERR_DEFERRED   8'h71
`define KEY_RECOVERED  4'h1
`define ASC_NO_LDPC    8'h17
`define ASC_LDPC       8'h18
`define Q17_RETRY      8'h01
`define Q17_REALLOC    8'h06
`define Q17_REWRITE    8'h09
`define Q18_PLAIN      8'h00
`define Q18_REALLOC    8'h02
`define Q18_REWRITE    8'h07
`define ACT_REALLOC    2'h1
`define ACT_REWRITE    2'h2
`define SCOPE_ONE      2'h1
`define SCOPE_INIT     2'h2
`define SCOPE_ALL      2'h3

// ----------------------------------------------------------------
// Register map (byte offsets) and control fields
// ----------------------------------------------------------------
`define REG_CONTROL    4'h0
`define REG_STATUS     4'h4
`define REG_OCCUPANCY  4'h8
`define REG_SENSE      4'hC
`define CTL_WCE        0
`define CTL_QERR       1
`define CTL_QAM_LO     4
`define CTL_QAM_HI     7
`define CTL_RESV_LO    8
`define CTL_RESV_HI    15
`define QAM_REORDER    4'h1
`define QUEUE_DEPTH    128

`endif

// >>> src/admit_pkg.sv
// Types shared by the command admission block.
// Assumes admit_consts.svh is compiled alongside.
package admit_pkg;

  typedef enum logic [1:0] {V_PERMIT, V_IGNORE, V_CONFLICT} verdict_t;

  typedef logic [5:0] init_id_t;
  typedef logic [7:0] count_t;

  typedef struct packed {
    logic                waitreq;
    logic [31:0]         rdata;
    logic                wce;
    logic                qerr;
    logic [3:0]          qam;
    logic [7:0]          int_resv;
    logic                reserved;
    init_id_t            maker;
    init_id_t            recip;
    logic                prio_busy;
    logic                ca;
    logic                defer_pend;
    logic [8:0]          total;
    logic [8:0]          extra;
    logic [63:0][7:0]    cnt;
    logic                resp_valid;
    logic [7:0]          resp_status;
    logic                resp_queued;
    logic                resp_head;
    logic                term_valid;
    logic [1:0]          term_scope;
    init_id_t            term_init;
    logic [7:0]          term_tag;
    logic                early_good;
    logic [7:0]          sense_err;
    logic [3:0]          sense_key;
    logic [7:0]          sense_asc;
    logic [7:0]          sense_ascq;
    logic [31:0]         sense_lba;
    logic                pend;
    logic [31:0]         pend_lba;
    logic                rewrite_req;
    logic                realloc_req;
    logic [31:0]         media_lba;
  } state_t;

endpackage

// >>> src/cmd_admission.sv
// Command admission for one logical unit: reservation check, priority
// commands, queue slot accounting, task termination, early write status
// with deferred errors, and auto rewrite/reallocate sense reporting.
// Assumes command, completion and media inputs come from logic on clk_sys.
// Notes on behaviour
// - Reserve stores both maker and recipient IDs; third-party allowed.
// - Maker that is also recipient may issue any command.
// - Stranger: Inquiry, Request Sense pass; Release ignored; rest conflict.
// - Maker only: Inquiry, Request Sense, Reserve, Release pass; rest conflict.
// - Recipient only: Reserve conflicts; Release ignored; rest pass.
// - After reservation, LUN, deferred error, then queue checks in order.
// - Inquiry, Request Sense, Report LUNs never get Busy or conflict.
// - Priority commands bypass the queue and run first.
// - Commands for an invalid LUN are never queued.
// - Every initiator keeps one slot; one may hold up to 128.
// - No free slot answers QUEUE FULL and does not enqueue.
// - Abort one, abort initiator set, or clear all initiators' tasks.
// - Reordering allowed only when the queue algorithm field permits.
// - Priority command during another goes to the queue head.
// - QErr decides fate of that initiator's tasks on CHECK CONDITION.
// - With WCE, Good status at last sector, before media commit.
// - Later error is deferred, code 71h, next command CHECK CONDITION.
// - Contingent allegiance suspends all queued processes.
// - Read error site pending; rewritten on next write if read ok.
// - Write No Sector Found site reallocated only if recovery succeeded.
// - Report key 1, code 17 or 18 and its qualifier; the LBA is stored but not readable.
`include "admit_consts.svh"

module cmd_admission
  import admit_pkg::*;
#(
  parameter int QDEPTH = `QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // Avalon-MM register slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Incoming command
  input  wire logic               cmd_valid,
  input  wire admit_pkg::init_id_t cmd_init,
  input  wire logic [7:0]         cmd_op,
  input  wire logic               cmd_lun_ok,
  input  wire logic               cmd_third_valid,
  input  wire admit_pkg::init_id_t cmd_third_id,
  // Admission answer
  output logic                    resp_valid,
  output logic [7:0]              resp_status,
  output logic                    resp_queued,
  output logic                    resp_head,
  // Completions from the execution engine
  input  wire logic               done_valid,
  input  wire admit_pkg::init_id_t done_init,
  input  wire logic               prio_done,
  input  wire logic               cc_valid,
  input  wire admit_pkg::init_id_t cc_init,
  // Task management
  input  wire logic               tmf_valid,
  input  wire logic [1:0]         tmf_code,
  input  wire admit_pkg::init_id_t tmf_init,
  input  wire logic [7:0]         tmf_tag,
  output logic                    term_valid,
  output logic [1:0]              term_scope,
  output admit_pkg::init_id_t     term_init,
  output logic [7:0]              term_tag,
  // Write cache and media events
  input  wire logic               wr_last_sector,
  input  wire logic               deferred_err,
  input  wire logic               media_write,
  input  wire logic               ev_valid,
  input  wire logic               ev_write,
  input  wire logic               ev_ok,
  input  wire logic               ev_ldpc,
  input  wire logic [1:0]         ev_action,
  input  wire logic [31:0]        ev_lba,
  output logic                    early_good,
  output logic                    rewrite_req,
  output logic                    realloc_req,
  output logic [31:0]             media_lba,
  // Queue control
  output logic                    suspend,
  output logic                    reorder_ok
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  localparam state_t RST_STATE = '{waitreq: 1'b1, default: '0};

  state_t   r;
  state_t   n;
  logic     is_prio;
  verdict_t verdict;
  logic     full_now;
  logic [8:0] limit;

  function automatic verdict_t resv_check(input logic rsv,
      input init_id_t mk, input init_id_t rc, input init_id_t who,
      input logic [7:0] op);
    logic is_mk;
    logic is_rc;
    logic info;
    is_mk = (who == mk);
    is_rc = (who == rc);
    info  = (op == `OP_REQ_SENSE) || (op == `OP_INQUIRY);
    if (!rsv || (is_mk && is_rc))
      return V_PERMIT;
    if (!is_mk && !is_rc)
    begin
      if (info)
        return V_PERMIT;
      return (op == `OP_RELEASE) ? V_IGNORE : V_CONFLICT;
    end
    if (is_mk)
    begin
      if (info || op == `OP_RESERVE || op == `OP_RELEASE)
        return V_PERMIT;
      return V_CONFLICT;
    end
    if (op == `OP_RESERVE)
      return V_CONFLICT;
    return (op == `OP_RELEASE) ? V_IGNORE : V_PERMIT;
  endfunction

  // Drops every queued task of one initiator from the slot accounting
  function automatic state_t drop_init(input state_t s, input init_id_t i);
    state_t t;
    t = s;
    if (t.cnt[i] != 8'h00)
    begin
      t.total = t.total - {1'b0, t.cnt[i]};
      t.extra = t.extra - {1'b0, t.cnt[i]} + 9'h001;
    end
    t.cnt[i] = 8'h00;
    return t;
  endfunction

  assign is_prio = (cmd_op == `OP_INQUIRY) || (cmd_op == `OP_REQ_SENSE) ||
                   (cmd_op == `OP_REPORT_LUNS);
  assign verdict = resv_check(r.reserved, r.maker, r.recip, cmd_init,
                              cmd_op);
  // First slot of each initiator is outside the shared pool, so one
  // initiator can reach QDEPTH minus int_resv while the others hold one each
  assign limit    = 9'(QDEPTH - 1) - {1'b0, r.int_resv};
  assign full_now = (r.cnt[cmd_init] != 8'h00) &&
                    (r.extra >= limit);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.resp_valid  = 1'b0;
    n.term_valid  = 1'b0;
    n.early_good  = 1'b0;
    n.rewrite_req = 1'b0;
    n.realloc_req = 1'b0;

    // One wait state; write lands on the edge that sees waitrequest low
    if ((avs_read || avs_write) && r.waitreq)
    begin
      n.waitreq = 1'b0;
      case (avs_address)
        `REG_CONTROL:   n.rdata = {16'h0000, r.int_resv, r.qam, 2'b00,
                                   r.qerr, r.wce};
        `REG_STATUS:    n.rdata = {10'h000, r.recip, 2'b00, r.maker,
                                   4'h0, r.prio_busy, r.defer_pend, r.ca,
                                   r.reserved};
        `REG_OCCUPANCY: n.rdata = {7'h00, r.extra, 7'h00, r.total};
        `REG_SENSE:     n.rdata = {r.sense_err, r.sense_ascq, r.sense_asc,
                                   4'h0, r.sense_key};
        default:        n.rdata = 32'h0000_0000;
      endcase
    end
    else
    begin
      n.waitreq = 1'b1;
    end
    if (avs_write && !r.waitreq && avs_address == `REG_CONTROL)
    begin
      n.wce      = avs_writedata[`CTL_WCE];
      n.qerr     = avs_writedata[`CTL_QERR];
      n.qam      = avs_writedata[`CTL_QAM_HI:`CTL_QAM_LO];
      n.int_resv = avs_writedata[`CTL_RESV_HI:`CTL_RESV_LO];
    end

    // Completions first; the full check uses registered counts, so a slot freed here serves only later commands
    if (prio_done)
      n.prio_busy = 1'b0;
    if (done_valid && n.cnt[done_init] != 8'h00)
    begin
      if (n.cnt[done_init] != 8'h01)
        n.extra = n.extra - 9'h001;
      n.cnt[done_init] = n.cnt[done_init] - 8'h01;
      n.total = n.total - 9'h001;
    end

    if (cmd_valid)
    begin
      n.resp_valid  = 1'b1;
      n.resp_status = `ST_GOOD;
      n.resp_queued = 1'b0;
      n.resp_head   = 1'b0;
      if (is_prio)
      begin
        // Executed at once, or at the queue head while another runs; never refused
        if (r.prio_busy)
          n.resp_head = 1'b1;
        else
          n.prio_busy = 1'b1;
        if (cmd_op == `OP_REQ_SENSE)
          n.ca = 1'b0;
      end
      else if (verdict == V_CONFLICT)
        n.resp_status = `ST_CONFLICT;
      else if (!cmd_lun_ok)
        n.resp_status = `ST_CHECK;
      else if (r.defer_pend)
      begin
        n.resp_status = `ST_CHECK;
        n.defer_pend  = 1'b0;
        n.ca          = 1'b1;
        n.sense_err   = `ERR_DEFERRED;
      end
      else if (verdict == V_IGNORE)
        n.resp_status = `ST_GOOD;
      else if (cmd_op == `OP_RESERVE)
      begin
        n.reserved = 1'b1;
        n.maker    = cmd_init;
        n.recip    = cmd_third_valid ? cmd_third_id : cmd_init;
      end
      else if (cmd_op == `OP_RELEASE)
        n.reserved = 1'b0;
      else if (full_now)
        n.resp_status = `ST_QFULL;
      else
      begin
        n.resp_queued = 1'b1;
        if (n.cnt[cmd_init] != 8'h00)
          n.extra = n.extra + 9'h001;
        n.cnt[cmd_init] = n.cnt[cmd_init] + 8'h01;
        n.total = n.total + 9'h001;
      end
    end

    // QErr set: the other tasks of the failing initiator are aborted
    if (cc_valid && r.qerr)
    begin
      n = drop_init(n, cc_init);
      n.term_valid = 1'b1;
      n.term_scope = `SCOPE_INIT;
      n.term_init  = cc_init;
      n.term_tag   = 8'h00;
    end

    if (tmf_valid)
    begin
      n.term_valid = 1'b1;
      n.term_init  = tmf_init;
      n.term_tag   = tmf_tag;
      case (tmf_code)
        `TMF_ABORT:
        begin
          n.term_scope = `SCOPE_ONE;
          if (n.cnt[tmf_init] != 8'h00)
          begin
            if (n.cnt[tmf_init] != 8'h01)
              n.extra = n.extra - 9'h001;
            n.cnt[tmf_init] = n.cnt[tmf_init] - 8'h01;
            n.total = n.total - 9'h001;
          end
        end
        `TMF_ABORT_SET:
        begin
          n = drop_init(n, tmf_init);
          n.term_scope = `SCOPE_INIT;
        end
        default:
        begin
          n.term_scope = `SCOPE_ALL;
          n.cnt        = '0;
          n.total      = 9'h000;
          n.extra      = 9'h000;
          n.ca         = 1'b0;
          n.prio_busy  = 1'b0;
          if (tmf_code == `TMF_TGT_RESET)
            n.reserved = 1'b0;
        end
      endcase
    end

    // Early status; a later failure is held for the next command
    if (wr_last_sector && r.wce)
      n.early_good = 1'b1;
    if (deferred_err)
      n.defer_pend = 1'b1;

    // Pending read site is rewritten by the next media write
    if (media_write && r.pend)
    begin
      n.rewrite_req = 1'b1;
      n.media_lba   = r.pend_lba;
      n.pend        = 1'b0;
    end
    if (ev_valid)
    begin
      n.sense_err  = `ERR_CURRENT;
      n.sense_key  = `KEY_RECOVERED;
      n.sense_lba  = ev_lba;
      n.sense_asc  = ev_ldpc ? `ASC_LDPC : `ASC_NO_LDPC;
      case (ev_action)
        `ACT_REALLOC: n.sense_ascq = ev_ldpc ? `Q18_REALLOC : `Q17_REALLOC;
        `ACT_REWRITE: n.sense_ascq = ev_ldpc ? `Q18_REWRITE : `Q17_REWRITE;
        default:      n.sense_ascq = ev_ldpc ? `Q18_PLAIN : `Q17_RETRY;
      endcase
      if (ev_ok && !ev_write)
      begin
        n.pend     = 1'b1;
        n.pend_lba = ev_lba;
      end
      if (ev_ok && ev_write)
      begin
        n.realloc_req = 1'b1;
        n.media_lba   = ev_lba;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      r <= RST_STATE;
    else
      r <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign resp_valid      = r.resp_valid;
  assign resp_status     = r.resp_status;
  assign resp_queued     = r.resp_queued;
  assign resp_head       = r.resp_head;
  assign term_valid      = r.term_valid;
  assign term_scope      = r.term_scope;
  assign term_init       = r.term_init;
  assign term_tag        = r.term_tag;
  assign early_good      = r.early_good;
  assign rewrite_req     = r.rewrite_req;
  assign realloc_req     = r.realloc_req;
  assign media_lba       = r.media_lba;
  assign suspend         = r.ca;
  assign reorder_ok      = (r.qam == `QAM_REORDER);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Pending deferred error that no same-cycle event re-arms or clears
  sequence s_defer_armed;
    r.defer_pend && !deferred_err && !tmf_valid;
  endsequence
  sequence s_plain_cmd;
    cmd_valid && !is_prio && verdict != V_CONFLICT && cmd_lun_ok;
  endsequence

  property p_conflict;
    cmd_valid && !is_prio && r.reserved && cmd_init != r.maker &&
      cmd_init != r.recip && cmd_op != `OP_RELEASE
      |=> resp_valid && resp_status == `ST_CONFLICT && !resp_queued;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("stranger command not refused with conflict");

  property p_prio_good;
    cmd_valid && is_prio |=> resp_status == `ST_GOOD && !resp_queued;
  endproperty
  a_prio_good: assert property (p_prio_good)
    else $error("priority command refused or queued");

  property p_lun_never_queued;
    cmd_valid && !cmd_lun_ok |=> !resp_queued;
  endproperty
  a_lun_never_queued: assert property (p_lun_never_queued)
    else $error("invalid unit command queued");

  property p_qfull;
    s_plain_cmd and (!r.defer_pend && full_now && cmd_op != `OP_RESERVE &&
      cmd_op != `OP_RELEASE && !done_valid)
      |=> resp_status == `ST_QFULL && !resp_queued;
  endproperty
  a_qfull: assert property (p_qfull)
    else $error("full queue did not answer queue full");

  property p_deferred;
    s_defer_armed and s_plain_cmd
      |=> resp_status == `ST_CHECK && suspend && !r.defer_pend;
  endproperty
  a_deferred: assert property (p_deferred)
    else $error("deferred error not reported on next command");

  property p_clear_all;
    tmf_valid && tmf_code == `TMF_CLEAR_SET
      |=> r.total == 9'h000 && term_scope == `SCOPE_ALL && !suspend;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clear task set left tasks in the queue");

  property p_qerr;
    cc_valid && r.qerr && !tmf_valid
      |=> term_valid && term_scope == `SCOPE_INIT &&
          term_init == $past(cc_init);
  endproperty
  a_qerr: assert property (p_qerr)
    else $error("qerr abort not issued");

  property p_early_good;
    wr_last_sector && r.wce
      |=> early_good ##1 (!early_good || $past(wr_last_sector));
  endproperty
  a_early_good: assert property (p_early_good)
    else $error("early good status missing");

  logic sense_key_ok;
  assign sense_key_ok = (r.sense_key == `KEY_RECOVERED);
  property p_realloc;
    ev_valid && ev_write |=> realloc_req == $past(ev_ok) &&
      sense_key_ok;
  endproperty
  a_realloc: assert property (p_realloc)
    else $error("write site reallocation mismatch");

  property p_bus_wait;
    (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("register access did not complete in one wait state");

endmodule // cmd_admission

// >>> tb/initiator_model.sv
// Initiator model: issues one untagged command at a time to the target.
// Assumes the admission block samples the command on rising clk_sys edges.
module initiator_model
  import admit_pkg::*;
(
  // Clock
  input  wire logic           clk_sys,
  // Command towards the target
  output logic                cmd_valid,
  output admit_pkg::init_id_t cmd_init,
  output logic [7:0]          cmd_op,
  output logic                cmd_lun_ok,
  output logic                cmd_third_valid,
  output admit_pkg::init_id_t cmd_third_id
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {cmd_valid, cmd_init, cmd_op} = '0;
    {cmd_lun_ok, cmd_third_valid, cmd_third_id} = '0;
  end

  // Only untagged commands exist on this interface
  // Released fields flip so a stale opcode is never read as fresh
  task automatic send(input init_id_t i, input logic [7:0] op,
                      input logic tv, input init_id_t t, input logic lun);
    @(posedge clk_sys);
    {cmd_valid, cmd_init, cmd_op, cmd_third_valid, cmd_third_id,
     cmd_lun_ok} <= {1'h1, i, op, tv, t, lun};
    @(posedge clk_sys);
    {cmd_valid, cmd_init, cmd_op} <= {1'h0, ~i, ~op};
    #1;
  endtask
endmodule // initiator_model

// >>> tb/test_cmd_admission.sv
// Self-checking bench for cmd_admission: command rows, then hand tests.
// Assumes admit_pkg and admit_consts.svh are compiled before this file.
`include "admit_consts.svh"
module test_cmd_admission;
  timeunit 1ns;
  timeprecision 1ps;
  import admit_pkg::*;

  typedef struct packed
  {
    init_id_t i; logic [7:0] op; init_id_t t; logic lun; logic [7:0] st;
  } row_t;
  localparam row_t ROWS [17] = '{
    '{6'h01, 8'h16, 6'h02, 1'h1, 8'h00}, '{6'h03, 8'h28, 6'h03, 1'h1, 8'h18},
    '{6'h03, 8'h28, 6'h03, 1'h0, 8'h18}, '{6'h03, 8'h12, 6'h03, 1'h1, 8'h00},
    '{6'h03, 8'hA0, 6'h03, 1'h1, 8'h00}, '{6'h03, 8'h17, 6'h03, 1'h1, 8'h00},
    '{6'h03, 8'h28, 6'h03, 1'h1, 8'h18}, '{6'h01, 8'h28, 6'h01, 1'h1, 8'h18},
    '{6'h01, 8'h16, 6'h02, 1'h1, 8'h00}, '{6'h02, 8'h16, 6'h02, 1'h1, 8'h18},
    '{6'h02, 8'h28, 6'h02, 1'h1, 8'h00}, '{6'h01, 8'h17, 6'h01, 1'h1, 8'h00},
    '{6'h03, 8'h28, 6'h03, 1'h1, 8'h00}, '{6'h04, 8'h16, 6'h04, 1'h1, 8'h00},
    '{6'h04, 8'h28, 6'h04, 1'h1, 8'h00}, '{6'h04, 8'h17, 6'h04, 1'h1, 8'h00},
    '{6'h03, 8'h28, 6'h03, 1'h0, 8'h02}};
  localparam logic [1:0] SC [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  localparam logic [7:0] QQ [6] = '{8'h01, 8'h06, 8'h09, 8'h00, 8'h02, 8'h07};

  logic        clk_sys, sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, ev_lba, media_lba, q;
  logic        cmd_valid, cmd_lun_ok, cmd_third_valid;
  init_id_t    cmd_init, cmd_third_id, tmf_init, term_init;
  init_id_t    done_init, cc_init;
  logic        done_valid, cc_valid;
  logic [7:0]  cmd_op, resp_status, tmf_tag, term_tag;
  logic        resp_valid, resp_queued, resp_head, term_valid;
  logic [1:0]  tmf_code, term_scope, ev_action;
  logic        prio_done, tmf_valid, wr_last_sector, deferred_err;
  logic        media_write, ev_valid, ev_write, ev_ok, ev_ldpc;
  logic        early_good, rewrite_req, realloc_req, suspend, reorder_ok;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // Small queue so the full case is reached in a few commands
  cmd_admission #(.QDEPTH(4)) DUT
  (
    .*
  );
  initiator_model ini
  (
    .*
  );

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Avalon master: holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    {avs_read, avs_write, avs_address, avs_writedata} <= {~wr, wr, a, d};
    // Values read right at the edge are the ones the slave shows there
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask

  // One pulse of completion {done, cc} for initiator 5
  task automatic side(input logic [1:0] v);
    @(posedge clk_sys);
    {done_valid, cc_valid, done_init, cc_init} <= {v, 6'h05, 6'h05};
    @(posedge clk_sys);
    {done_valid, cc_valid} <= 2'h0;
    #1;
  endtask

  task automatic pulse(input logic [5:0] m, input logic [20:0] f,
                       input logic [31:0] l);
    @(posedge clk_sys);
    {prio_done, tmf_valid, wr_last_sector, deferred_err, media_write,
     ev_valid, ev_write, ev_ok, ev_ldpc, ev_action, tmf_code, tmf_init,
     tmf_tag, ev_lba} <= {m, f, l};
    @(posedge clk_sys);
    {prio_done, tmf_valid, wr_last_sector, deferred_err, media_write,
     ev_valid} <= 6'h00;
    #1;
  endtask

  task automatic cmd(input init_id_t i, input logic [7:0] op,
                     input logic [7:0] st);
    ini.send(i, op, 1'h0, 6'h00, 1'h1);
    chk({resp_valid, resp_status}, {1'h1, st});
  endtask

  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    row_t r;
    sys_rst = 1'h1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {prio_done, tmf_valid, wr_last_sector, deferred_err, media_write,
     ev_valid, ev_write, ev_ok, ev_ldpc, ev_action, tmf_code, tmf_init,
     tmf_tag, ev_lba} = '0;
    {done_valid, cc_valid, done_init, cc_init} = '0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1;
    chk({avs_waitrequest, resp_valid, suspend}, 3'h4);
    foreach (ROWS[n])
    begin
      r = ROWS[n];
      ini.send(r.i, r.op, 1'h1, r.t, r.lun);
      chk({resp_valid, resp_status}, {1'h1, r.st});
      chk(resp_queued & ~r.lun, 1'h0);
    end
    for (int j = 0; j < 5; j++)
    begin
      cmd(6'h05, 8'h28, j < 4 ? 8'h00 : 8'h28);
      chk(resp_queued, j < 4);
    end
    side(2'h2);
    cmd(6'h05, 8'h28, 8'h00);
    chk(resp_queued, 1'h1);
    cmd(6'h06, 8'h28, 8'h00);
    chk(resp_queued, 1'h1);
    for (int c = 0; c < 4; c++)
    begin
      pulse(6'h10, {5'h00, 2'(c), 6'h05, 8'h07}, 32'h0);
      chk({term_valid, term_scope, term_init, term_tag},
          {1'h1, SC[c], 6'h05, 8'h07});
    end
    pulse(6'h20, 21'h0, 32'h0);
    cmd(6'h01, 8'h12, 8'h00);
    chk({resp_queued, resp_head}, 2'h0);
    cmd(6'h02, 8'h12, 8'h00);
    chk({resp_queued, resp_head}, 2'h1);
    chk(reorder_ok, 1'h0);
    bus(1'h1, 4'h0, 32'h0000_0013);
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h0000_0013);
    chk(reorder_ok, 1'h1);
    side(2'h1);
    chk({term_valid, term_scope, term_init}, {1'h1, 2'h2, 6'h05});
    bus(1'h0, 4'h1, 32'h0);
    chk(q, 32'h0);
    pulse(6'h08, 21'h0, 32'h0);
    chk(early_good, 1'h1);
    pulse(6'h04, 21'h0, 32'h0);
    cmd(6'h06, 8'h28, 8'h02);
    chk(suspend, 1'h1);
    bus(1'h0, 4'hC, 32'h0);
    chk(q[31:24], 8'h71);
    cmd(6'h03, 8'h03, 8'h00);
    chk(suspend, 1'h0);
    for (int k = 0; k < 6; k++)
    begin
      pulse(6'h01, {2'h1, 1'(k / 3), 2'(k % 3), 16'h0}, 32'h100 + k);
      bus(1'h0, 4'hC, 32'h0);
      chk(q, {8'h70, QQ[k], k < 3 ? 8'h17 : 8'h18, 8'h01});
    end
    pulse(6'h02, 21'h0, 32'h0);
    chk({rewrite_req, media_lba}, {1'h1, 32'h105});
    pulse(6'h01, 21'h0, 32'h300);
    pulse(6'h02, 21'h0, 32'h0);
    chk(rewrite_req, 1'h0);
    pulse(6'h01, {2'h2, 19'h0}, 32'h200);
    chk(realloc_req, 1'h0);
    pulse(6'h01, {2'h3, 1'h0, 2'h1, 16'h0}, 32'h201);
    chk({realloc_req, media_lba}, {1'h1, 32'h201});
    cmd(6'h01, 8'h16, 8'h00);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    cmd(6'h03, 8'h28, 8'h00);
    conclude();
  end
endmodule // test_cmd_admission
